// >>> dma_status_cfg.svh
// Register offsets, field positions and reset values of the DMA channel block
`ifndef DMA_STATUS_CFG_SVH
`define DMA_STATUS_CFG_SVH

`define DMA_NUM_CHAN          8
`define DMA_CHAN_STRIDE       12'h020
`define DMA_CHAN_SPAN_END     12'h100
`define DMA_OFS_CTRL          5'h00
`define DMA_OFS_PERIPH        5'h04
`define DMA_OFS_COUNT         5'h08
`define DMA_OFS_PRIMARY       5'h0c
`define DMA_OFS_SECONDARY     5'h10
`define DMA_OFS_COLLISION     12'h100
`define DMA_OFS_ACTIVITY      12'h104
`define DMA_OFS_LAST_RAM      12'h108
`define DMA_OFS_INT_STATUS    12'h10c
`define DMA_OFS_INT_MASK      12'h110

`define DMA_CTRL_ENABLE_BIT   15
`define DMA_CTRL_DIR_BIT      13
`define DMA_CTRL_MODE_LSB     0
`define DMA_COUNT_W           10
`define DMA_PERIPH_COL_LSB    8
`define DMA_LAST_CH_LSB       8
`define DMA_LAST_CH_NONE      4'hf
`define DMA_ADDR_RESET        16'h0000

`endif

// >>> dma_status_pkg.sv
// Types shared by the DMA channel block and its surroundings
package dma_status_pkg;

   typedef struct packed {
      logic        periph_valid;
      logic [15:0] periph_addr;
      logic        ram_valid;
      logic [15:0] ram_addr;
   } cpu_write_t;

   typedef struct packed {
      logic        valid;
      logic [2:0]  chan;
      logic        to_periph;
      logic [15:0] periph_addr;
      logic [15:0] ram_addr;
   } xfer_t;

   typedef struct packed {
      logic        enable;
      logic        dir;
      logic [1:0]  mode;
      logic [15:0] periph;
      logic [9:0]  count;
      logic [15:0] primary;
      logic [15:0] secondary;
      logic [9:0]  index;
      logic        pingpong;
      logic        pending;
   } chan_t;

   typedef struct packed {
      logic        hit;
      logic        is_chan;
      logic [2:0]  chan;
      logic [4:0]  sel;
   } decode_t;

endpackage

// >>> dma_channel_addr_count_status.sv
// Eight-channel DMA engine with address, count and controller status registers
`timescale 1ns/1ps
`include "dma_status_cfg.svh"

module dma_channel_addr_count_status #(
   parameter int ADDR_W = 12
) (
   input  wire logic                      core_clk,
   input  wire logic                      rst,
   input  wire logic [ADDR_W-1:0]         paddr,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [31:0]               pwdata,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   input  wire logic [7:0]                dma_req,
   input  wire dma_status_pkg::cpu_write_t cpu_write,
   output dma_status_pkg::xfer_t          xfer,
   output logic                           irq
);

   typedef struct packed {
      dma_status_pkg::chan_t [7:0] ch;
      logic [15:0]                 collision;
      logic [3:0]                  last_chan;
      logic [15:0]                 last_ram;
      logic [7:0]                  int_status;
      logic [7:0]                  int_mask;
      dma_status_pkg::xfer_t       xfer;
      logic                        ready;
      logic                        slverr;
      logic [31:0]                 rdata;
   } state_t;

   state_t s;
   state_t next_s;

   // Maps a byte address onto a channel register or a global register
   function automatic dma_status_pkg::decode_t decode(input logic [ADDR_W-1:0] a);
      dma_status_pkg::decode_t d;
      logic [11:0]             a12;
      d   = '0;
      a12 = 12'(a);
      if (a12 < `DMA_CHAN_SPAN_END)
      begin
         d.is_chan = 1'b1;
         d.chan    = a12[7:5];
         d.sel     = a12[4:0];
         d.hit     = (a12[4:0] <= `DMA_OFS_SECONDARY) && (a12[1:0] == 2'b00);
      end
      else
      begin
         d.sel = 5'h00;
         d.hit = (a12 == `DMA_OFS_COLLISION) || (a12 == `DMA_OFS_ACTIVITY) ||
                 (a12 == `DMA_OFS_LAST_RAM) || (a12 == `DMA_OFS_INT_STATUS) ||
                 (a12 == `DMA_OFS_INT_MASK);
      end
      return d;
   endfunction

   // Start address currently selected by a channel
   function automatic logic [15:0] block_base(input dma_status_pkg::chan_t c);
      return c.pingpong ? c.secondary : c.primary;
   endfunction

   // Ping-pong status bits of all channels, channel 7 highest
   function automatic logic [7:0] pp_bits(input state_t st);
      logic [7:0] b;
      b = '0;
      for (int i = 0; i < `DMA_NUM_CHAN; i++)
      begin
         b[i] = st.ch[i].pingpong;
      end
      return b;
   endfunction

   function automatic logic [31:0] read_value(input state_t st, input logic [ADDR_W-1:0] a);
      dma_status_pkg::decode_t d;
      dma_status_pkg::chan_t   c;
      logic [31:0]             v;
      d = decode(a);
      c = st.ch[d.chan];
      v = '0;
      if (d.is_chan)
      begin
         unique case (d.sel)
            `DMA_OFS_CTRL:
            begin
               v[`DMA_CTRL_ENABLE_BIT]           = c.enable;
               v[`DMA_CTRL_DIR_BIT]              = c.dir;
               v[`DMA_CTRL_MODE_LSB +: 2]        = c.mode;
            end
            `DMA_OFS_PERIPH:
            begin
               v[15:0] = c.periph;
            end
            `DMA_OFS_COUNT:
            begin
               v[`DMA_COUNT_W-1:0] = c.count;
            end
            `DMA_OFS_PRIMARY:
            begin
               v[15:0] = c.primary;
            end
            `DMA_OFS_SECONDARY:
            begin
               v[15:0] = c.secondary;
            end
            default:
            begin
               v = '0;
            end
         endcase
      end
      else
      begin
         unique case (12'(a))
            `DMA_OFS_COLLISION:  v[15:0] = st.collision;
            `DMA_OFS_ACTIVITY:
            begin
               v[`DMA_LAST_CH_LSB +: 4] = st.last_chan;
               v[7:0]                   = pp_bits(st);
            end
            `DMA_OFS_LAST_RAM:   v[15:0] = st.last_ram;
            `DMA_OFS_INT_STATUS: v[7:0]  = st.int_status;
            `DMA_OFS_INT_MASK:   v[7:0]  = st.int_mask;
            default:             v = '0;
         endcase
      end
      return v;
   endfunction

   always_comb
   begin
      dma_status_pkg::decode_t d;
      logic                    wr;
      logic                    found;
      logic [2:0]              win;
      logic [15:0]             ram;
      logic [15:0]             col_set;
      logic [7:0]              done_set;
      d        = decode(paddr);
      wr       = psel && penable && pwrite && s.ready;
      found    = 1'b0;
      win      = 3'd0;
      ram      = '0;
      col_set  = '0;
      done_set = '0;
      next_s   = s;

      // One wait state so read data leaves a flip-flop
      next_s.ready  = psel && penable && !s.ready;
      next_s.slverr = psel && penable && !s.ready && !d.hit;
      if (psel && penable && !s.ready)
      begin
         next_s.rdata = read_value(s, paddr);
      end

      if (wr && d.hit)
      begin
         if (d.is_chan)
         begin
            unique case (d.sel)
               `DMA_OFS_CTRL:
               begin
                  next_s.ch[d.chan].enable = pwdata[`DMA_CTRL_ENABLE_BIT];
                  next_s.ch[d.chan].dir    = pwdata[`DMA_CTRL_DIR_BIT];
                  next_s.ch[d.chan].mode   = pwdata[`DMA_CTRL_MODE_LSB +: 2];
                  // A request left by a disabled channel must not fire on re-enable
                  if (!pwdata[`DMA_CTRL_ENABLE_BIT])
                  begin
                     next_s.ch[d.chan].pending = 1'b0;
                  end
                  // cleared on re-enable or outside ping-pong
                  if (!s.ch[d.chan].enable || !pwdata[`DMA_CTRL_MODE_LSB + 1])
                  begin
                     next_s.ch[d.chan].pingpong = 1'b0;
                     next_s.ch[d.chan].index    = '0;
                  end
               end
               `DMA_OFS_PERIPH:
               begin
                  next_s.ch[d.chan].periph = pwdata[15:0];
               end
               `DMA_OFS_COUNT:
               begin
                  next_s.ch[d.chan].count = pwdata[`DMA_COUNT_W-1:0];
               end
               `DMA_OFS_PRIMARY:
               begin
                  next_s.ch[d.chan].primary = pwdata[15:0];
               end
               `DMA_OFS_SECONDARY:
               begin
                  next_s.ch[d.chan].secondary = pwdata[15:0];
               end
               default:
               begin
                  next_s.ch[d.chan].pending = s.ch[d.chan].pending;
               end
            endcase
         end
         else
         begin
            unique case (12'(paddr))
               `DMA_OFS_COLLISION:
               begin
                  next_s.collision = s.collision & ~pwdata[15:0];
               end
               `DMA_OFS_INT_STATUS:
               begin
                  next_s.int_status = s.int_status & ~pwdata[7:0];
               end
               `DMA_OFS_INT_MASK:
               begin
                  next_s.int_mask = pwdata[7:0];
               end
               default:
               begin
                  next_s.int_mask = s.int_mask;
               end
            endcase
         end
      end

      // compare the transfer on the bus with the CPU write this cycle
      for (int i = 0; i < `DMA_NUM_CHAN; i++)
      begin
         if (s.xfer.valid && (s.xfer.chan == 3'(i)))
         begin
            col_set[`DMA_PERIPH_COL_LSB + i] = s.xfer.to_periph && cpu_write.periph_valid &&
                                               (cpu_write.periph_addr == s.xfer.periph_addr);
            col_set[i] = !s.xfer.to_periph && cpu_write.ram_valid &&
                         (cpu_write.ram_addr == s.xfer.ram_addr);
         end
      end

      // Lowest channel number wins when several are pending
      next_s.xfer.valid = 1'b0;
      for (int i = `DMA_NUM_CHAN - 1; i >= 0; i--)
      begin
         if (s.ch[i].pending && s.ch[i].enable)
         begin
            found = 1'b1;
            win   = 3'(i);
         end
      end

      if (found)
      begin
         ram                       = block_base(s.ch[win]) + {6'h00, s.ch[win].index};
         next_s.ch[win].pending    = 1'b0;
         next_s.xfer.valid         = 1'b1;
         next_s.xfer.chan          = win;
         next_s.xfer.to_periph     = s.ch[win].dir;
         next_s.xfer.periph_addr   = s.ch[win].periph;
         next_s.xfer.ram_addr      = ram;
         // replaces the all-ones reset code at the first transfer
         next_s.last_chan          = {1'b0, win};
         next_s.last_ram           = ram;
         // block ends after count plus one transfers
         if (s.ch[win].index == s.ch[win].count)
         begin
            next_s.ch[win].index = '0;
            done_set[win]        = 1'b1;
            // toggle at block end in ping-pong mode
            if (s.ch[win].mode[1])
            begin
               next_s.ch[win].pingpong = !s.ch[win].pingpong;
            end
            // One-shot stops after one block, or after both buffers in ping-pong
            if (s.ch[win].mode[0] && (!s.ch[win].mode[1] || s.ch[win].pingpong))
            begin
               next_s.ch[win].enable = 1'b0;
            end
         end
         else
         begin
            next_s.ch[win].index = s.ch[win].index + 10'd1;
         end
      end

      // Requests latch after the serve so a new one in the same cycle is kept
      for (int i = 0; i < `DMA_NUM_CHAN; i++)
      begin
         if (dma_req[i] && next_s.ch[i].enable)
         begin
            next_s.ch[i].pending = 1'b1;
         end
      end

      // hardware set wins over a software clear
      next_s.collision  = next_s.collision | col_set;
      next_s.int_status = next_s.int_status | done_set;
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         s           <= '0;
         s.last_chan <= `DMA_LAST_CH_NONE;
         s.last_ram  <= `DMA_ADDR_RESET;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign prdata  = s.rdata;
   assign pready  = s.ready;
   assign pslverr = s.slverr;
   assign xfer    = s.xfer;
   assign irq     = |(s.int_status & s.int_mask);

endmodule

// >>> dma_status_monitor.sv
// Port-level assertions for the DMA channel and status block
`timescale 1ns/1ps
module dma_status_monitor #(
   parameter int ADDR_W = 12
) (
   input wire logic                       core_clk,
   input wire logic                       rst,
   input wire logic [ADDR_W-1:0]          paddr,
   input wire logic                       psel,
   input wire logic                       penable,
   input wire logic                       pwrite,
   input wire logic [31:0]                pwdata,
   input wire logic [31:0]                prdata,
   input wire logic                       pready,
   input wire logic                       pslverr,
   input wire logic [7:0]                 dma_req,
   input wire dma_status_pkg::cpu_write_t cpu_write,
   input wire dma_status_pkg::xfer_t      xfer,
   input wire logic                       irq
);
   wire rd = pready && !pwrite;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence s_setup; psel && !penable; endsequence
   sequence s_answer; !pready ##1 pready; endsequence
   a_apb_wait: assert property (s_setup |=> s_answer)
      else $error("access not answered after one wait");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_err_zero: assert property (pslverr |-> pready && prdata == 0)
      else $error("refused access returned data");
   a_unmapped_err: assert property (rd && paddr >= 12'h114 |-> pslverr)
      else $error("unmapped read not refused");
   a_count_upper: assert property (rd && paddr < 12'h100 && paddr[4:0] == 5'h08
      |-> prdata[31:10] == 0)
      else $error("count upper bits not zero");
   a_last_code: assert property (rd && paddr == 12'h104 |-> prdata[31:12] == 0
      && (!prdata[11] || prdata[11:8] == 4'hf))
      else $error("reserved last channel code");
   a_status_width: assert property (rd && (paddr == 12'h100 || paddr == 12'h108)
      |-> prdata[31:16] == 0)
      else $error("status upper bits not zero");
   a_reset_quiet: assert property ($fell(rst) |-> !pready && !xfer.valid && !irq)
      else $error("outputs active out of reset");
endmodule

bind dma_channel_addr_count_status dma_status_monitor #(.ADDR_W(ADDR_W)) i_mon (.*);

// >>> dma_far_model.sv
// Far-side writer that can hit the DMA write target in the same cycle
`timescale 1ns/1ps
module dma_far_model (
   input wire dma_status_pkg::xfer_t  xfer,
   input wire logic                   collide,
   output dma_status_pkg::cpu_write_t cpu_write
);
   always_comb
   begin
      cpu_write.periph_valid = collide && xfer.valid && xfer.to_periph;
      cpu_write.ram_valid = collide && xfer.valid && !xfer.to_periph;
      // Idle address lines never sit on the target, so no stale match
      cpu_write.periph_addr = cpu_write.periph_valid ? xfer.periph_addr : ~xfer.periph_addr;
      cpu_write.ram_addr = cpu_write.ram_valid ? xfer.ram_addr : ~xfer.ram_addr;
   end
endmodule

// >>> tb_dma_channel_addr_count_status.sv
// Self-checking bench for the DMA channel address, count and status block
`timescale 1ns/1ps
module tb_dma_channel_addr_count_status;
   logic                       core_clk, rst, psel, penable, pwrite, pready, pslverr, irq, collide;
   logic [11:0]                paddr;
   logic [31:0]                pwdata, prdata, rs;
   logic [7:0]                 dma_req;
   dma_status_pkg::cpu_write_t cpu_write;
   dma_status_pkg::xfer_t      xfer;
   logic [32:0]                rq[$];
   logic [35:0]                xq[$];
   int                         n_errors, check_count;

   dma_channel_addr_count_status i_dma_channel_addr_count_status (.*);
   dma_far_model i_dma_far_model (.*);

   initial
   begin
      core_clk = 0;
      forever #2.5 core_clk = ~core_clk;
   end

   task automatic chk(input string s, input logic [35:0] e, input logic [35:0] g);
      check_count++;
      if (e !== g)
      begin
         n_errors++;
         $display("[ERR] %s exp %h got %h", s, e, g);
      end
   endtask

   task automatic finish_test;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Read expectations are queued before the access starts
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [32:0] e);
      int n;
      if (!w)
         rq.push_back(e);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1;
      n = 0;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      psel <= 0;
      penable <= 0;
      @(posedge core_clk);
      if (n >= 20)
      begin
         chk("ready", 0, 1);
         finish_test;
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1, a, d, 0);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(0, a, 0, {1'b0, e});
   endtask

   task automatic xp(input logic [2:0] c, input logic t, input logic [15:0] p,
                     input logic [15:0] a);
      xq.push_back({c, t, p, a});
   endtask

   // Trailing idle cycles give a refused request time to show up wrongly
   task automatic req(input logic [7:0] m);
      dma_req <= m;
      @(posedge core_clk);
      dma_req <= 0;
      for (int n = 0; n < 40 && xq.size() > 0; n++)
         @(posedge core_clk);
      repeat (4) @(posedge core_clk);
      if (xq.size() > 0)
      begin
         chk("xfer wait", 0, 1);
         finish_test;
      end
   endtask

   always @(posedge core_clk)
   begin
      if (pready && !pwrite)
         chk("read", rq.size() ? rq.pop_front() : 'x, {pslverr, prdata});
      if (xfer.valid === 1'b1)
         chk("xfer", xq.size() ? xq.pop_front() : 'x,
             {xfer.chan, xfer.to_periph, xfer.periph_addr, xfer.ram_addr});
   end

   initial
   begin
      {psel, penable, pwrite, collide} = 0;
      paddr = 0;
      pwdata = 0;
      dma_req = 0;
      rst = 1;
      rs = 32'haf90;
      n_errors = 0;
      check_count = 0;
      repeat (20) @(posedge core_clk);
      rst <= 0;
      @(posedge core_clk);
      rd(12'h100, 0);
      rd(12'h104, 32'h0f00);
      rd(12'h108, 0);
      rd(12'h0e8, 0);
      rd(12'h044, 0);
      rs = lfsr(rs);
      wr(12'h044, rs);
      wr(12'h064, {16'h0, ~rs[15:0]});
      rd(12'h044, {16'h0, rs[15:0]});
      wr(12'h0e8, 32'hffff_ffff);
      rd(12'h0e8, 32'h3ff);
      $display("test registers done");
      wr(12'h068, 2);
      wr(12'h06c, 32'h40);
      wr(12'h070, 32'h80);
      wr(12'h110, 8);
      wr(12'h060, 32'h8002);
      for (int i = 0; i < 3; i++)
      begin
         xp(3, 0, ~rs[15:0], 16'h40 + 16'(i));
         req(8'h08);
         chk("irq", 33'(i == 2), 33'(irq));
      end
      rd(12'h104, 32'h0308);
      rd(12'h108, 32'h42);
      wr(12'h10c, 8);
      @(posedge core_clk);
      chk("irq", 0, 33'(irq));
      $display("test blocks done");
      collide <= 1;
      xp(3, 0, ~rs[15:0], 16'h80);
      req(8'h08);
      collide <= 0;
      rd(12'h100, 32'h8);
      wr(12'h100, 0);
      rd(12'h100, 32'h8);
      wr(12'h100, 32'hffff);
      rd(12'h100, 0);
      wr(12'h060, 0);
      wr(12'h060, 32'ha000);
      collide <= 1;
      xp(3, 1, ~rs[15:0], 16'h40);
      req(8'h08);
      collide <= 0;
      rd(12'h100, 32'h800);
      rd(12'h104, 32'h0300);
      $display("test collisions done");
      wr(12'h00c, 32'h10);
      wr(12'h000, 32'h8000);
      req(8'h20);
      xp(0, 0, 16'h0, 16'h10);
      xp(3, 1, ~rs[15:0], 16'h41);
      req(8'h09);
      xp(0, 0, 16'h0, 16'h10);
      req(8'h01);
      rd(12'h104, 0);
      rd(12'h10c, 1);
      apb(0, 12'h114, 0, {1'b1, 32'h0});
      $display("test arbitration done");
      // One-shot ping-pong runs one block per buffer, then drops its enable
      wr(12'h02c, 32'h200);
      wr(12'h030, 32'h300);
      wr(12'h020, 32'h8003);
      xp(1, 0, 16'h0, 16'h200);
      req(8'h02);
      xp(1, 0, 16'h0, 16'h300);
      req(8'h02);
      req(8'h02);
      rd(12'h020, 32'h3);
      rd(12'h104, 32'h0100);
      wr(12'h020, 32'h8001);
      xp(1, 0, 16'h0, 16'h200);
      req(8'h02);
      req(8'h02);
      rd(12'h020, 32'h1);
      $display("test one-shot done");
      finish_test;
   end
endmodule
